// ===== arc_adc_model.sv
// A/D converter stand-in
`timescale 1ns/1ps
`default_nettype none

module arc_adc_model (
    input wire logic [1:0] enMode,
    input wire logic [16:0] base,
    output logic adcClk,
    output logic [16:0] adcData,
    output logic enableN
);
    logic [2:0] chan;
    initial
    begin
        adcClk = 1'b0;
        adcData = 17'h0;
        enableN = 1'b1;
        chan = 3'h0;
        forever #16 adcClk = ~adcClk;
    end
    // launch on falling edge
    always @(negedge adcClk)
    begin
        chan <= chan + 3'h1;
        adcData <= (enMode == 2'h2) ? {base[16:3], chan} : base;
        enableN <= (enMode == 2'h2) ? (chan != 3'h0) : enMode[0];
    end
endmodule
`default_nettype wire

// ===== arc_input_range.sv
// input select/format stage with A/D range control, AHB-Lite registers
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "arc_map.svh"

// Notes on behaviour
// RULE1: all channel processing steps on the processing clock tick
// RULE2: capture on either edge of link clock or processing clock
// RULE3: fixed point or float mantissa/exponent 14/3, 15/2, 16/1
// RULE4: external exponent adds to range exponent; control bit 3 ignores it
// RULE5: two's complement or offset binary, selectable, fixed and float
// RULE6: gated mode takes one sample per enabled tick, else stalls
// RULE7: interpolated mode zeroes the sample while enable high, keeps running
// RULE8: source keeps constant spacing between enables in interpolated mode
// RULE9: mux mode delays enable 0 to 7 ticks to load selection register
// RULE10: register after selection is loaded by the undelayed enable
// RULE11: source gives one-tick enable pulse aligned with first channel
// RULE12: control bit 4 reverses the input bus bit order
// RULE13: register writes take effect together on a processing clock tick
// RULE14: average above upper adds up step, below lower subtracts down step
// RULE15: top three attenuator bits set gain, weighted 6, 12 and 24 dB
// RULE16: any sample above immediate threshold adds immediate step at once
// RULE17: immediate threshold ignored for programmed ticks after it fires
// RULE18: average between thresholds subtracts bias to reduce attenuation
// RULE19: slot counter with sync reset, start delay, integration, periods
// RULE20: immediate decisions on every sample regardless of slot counters
// RULE21: programmed 8-bit gain code output for each top-three-bit state
// RULE22: top bits routed as exponent, summed with input, delay programmed
// RULE23: attenuator register saturates at its limits instead of wrapping
module arc_input_range
    import arc_pkg::*;
#(
    parameter int DIV = `ARC_PROC_DIV
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic adc_clk,
    input wire logic [16:0] adc_data,
    input wire logic input_enable_n,
    input wire logic sync_pulse_in,
    output arc_pkg::arc_smp_t smp_out,
    output logic [7:0] gain_code
);
    import arc_pkg::*;

    typedef struct packed {
        arc_cfg_t cfg;
        logic [31:0] pend;
        logic [7:0] pendAddr;
        logic pendValid;
        logic [7:0] aphAddr;
        logic aphWrite;
        logic [31:0] hrdata;
        logic [7:0] divCnt;
        logic clkPrev;
        logic syncPrev;
        logic [16:0] cap;
        logic capEnN;
        logic [7:0] enLine;
        logic [15:0] selData;
        logic [3:0] selExp;
        arc_smp_t out;
        logic [7:0] att;
        logic [15:0] hold;
        logic [15:0] slotCnt;
        logic [15:0] dlyCnt;
        logic [15:0] intCnt;
        logic [7:0] perLeft;
        arc_phase_t phase;
        logic [31:0] acc;
        logic [7:0][2:0] expLine;
        logic [7:0] eout;
    } arc_st_t;

    localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
    localparam logic [7:0] DIV_HALF = 8'(DIV / 2 - 1);

    if (DIV < 2 || DIV > 256)
    begin : g_bad_div
        $error("arc_input_range: DIV must lie in 2..256");
    end

    arc_st_t s_r;
    arc_st_t s_nxt;
    logic [19:0] synIn;
    logic synClk;
    logic synEnN;
    logic synSync;
    logic [16:0] synData;
    logic procTick;
    logic procFall;
    logic capEv;
    logic [16:0] raw;
    logic [15:0] man;
    logic [2:0] inExp;
    logic [2:0] extExp;
    logic [3:0] expAdd;
    logic en;
    logic enDly;
    logic [15:0] mag;
    logic rcValid;
    logic immHit;
    logic slotStart;
    logic decide;
    logic [15:0] intLast;
    logic [31:0] avg;
    logic signed [10:0] delta;
    logic signed [10:0] attSum;
    logic accept;

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    arc_sync2 #(
        .WIDTH(20)
    ) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .asyncIn({sync_pulse_in, input_enable_n, adc_clk, adc_data}),
        .syncOut(synIn)
    );

    assign synData = synIn[16:0];
    assign synClk = synIn[17];
    assign synEnN = synIn[18];
    assign synSync = synIn[19];

    function automatic logic [16:0] arc_rev(input logic [16:0] v);
        logic [16:0] r;
        r = '0;
        for (int i = 0; i < 17; i++)
            r[i] = v[16 - i];
        return r;
    endfunction

    function automatic logic [7:0] arc_sat(input logic signed [10:0] v);
        if (v < 11'sd0)
            return 8'h00;
        else if (v > 11'sd255)
            return 8'hFF;
        else
            return v[7:0];
    endfunction

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        // processing tick
        procTick = (s_r.divCnt == DIV_LAST); // RULE1
        procFall = (s_r.divCnt == DIV_HALF);
        s_nxt.divCnt = procTick ? 8'h00 : s_r.divCnt + 8'h01;
        s_nxt.clkPrev = synClk;
        s_nxt.syncPrev = synSync;

        // capture edge select
        case (s_r.cfg.capSel) // RULE2
            2'h0: capEv = synClk & ~s_r.clkPrev;
            2'h1: capEv = ~synClk & s_r.clkPrev;
            2'h2: capEv = procTick;
            default: capEv = procFall;
        endcase
        if (capEv)
        begin
            s_nxt.cap = synData;
            s_nxt.capEnN = synEnN;
        end

        // bit order and number format
        raw = s_r.cfg.reverse ? arc_rev(s_r.cap) : s_r.cap; // RULE12
        case (s_r.cfg.fmt) // RULE3
            2'h0:
            begin
                man = raw[15:0];
                inExp = 3'h0;
            end
            2'h1:
            begin
                man = {raw[16:3], 2'h0};
                inExp = raw[2:0];
            end
            2'h2:
            begin
                man = {raw[16:2], 1'h0};
                inExp = {1'h0, raw[1:0]};
            end
            default:
            begin
                man = raw[16:1];
                inExp = {2'h0, raw[0]};
            end
        endcase
        if (s_r.cfg.offsetBin)
            man[15] = ~man[15]; // RULE5
        extExp = s_r.cfg.extExpIgnore ? 3'h0 : inExp; // RULE4
        expAdd = s_r.cfg.routeExp
            ? {1'h0, s_r.expLine[s_r.cfg.expDelay]} : 4'h0; // RULE22
        mag = man[15] ? 16'(~man + 16'h0001) : man;

        // enable handling and sample output
        en = ~s_r.capEnN;
        enDly = (s_r.cfg.muxDelay == 3'h0) ? en
            : s_r.enLine[3'(s_r.cfg.muxDelay - 3'h1)]; // RULE9
        s_nxt.out.valid = 1'b0;
        if (procTick)
        begin
            s_nxt.enLine = {s_r.enLine[6:0], en};
            case (s_r.cfg.mode)
                ARC_GATED:
                begin
                    s_nxt.out.valid = en; // RULE6
                    if (en)
                    begin
                        s_nxt.out.data = man;
                        s_nxt.out.exp = {1'h0, extExp} + expAdd; // RULE4
                    end
                end
                ARC_INTERP:
                begin
                    s_nxt.out.valid = 1'b1; // RULE7
                    s_nxt.out.data = en ? man : 16'h0000;
                    s_nxt.out.exp = en ? {1'h0, extExp} + expAdd : 4'h0;
                end
                ARC_MUX:
                begin
                    if (enDly)
                    begin
                        s_nxt.selData = man; // RULE9
                        s_nxt.selExp = {1'h0, extExp};
                    end
                    s_nxt.out.valid = en;
                    if (en)
                    begin
                        s_nxt.out.data = s_r.selData; // RULE10
                        s_nxt.out.exp = s_r.selExp + expAdd;
                    end
                end
                default:
                begin
                    s_nxt.out.valid = 1'b1;
                    s_nxt.out.data = man;
                    s_nxt.out.exp = {1'h0, extExp} + expAdd;
                end
            endcase
        end

        // immediate threshold, every sample
        rcValid = procTick & ((s_r.cfg.mode == ARC_CONT)
            | (s_r.cfg.mode == ARC_MUX) | en);
        immHit = rcValid & (mag > s_r.cfg.thrImm)
            & (s_r.hold == 16'h0000); // RULE16 RULE20
        if (immHit)
            s_nxt.hold = s_r.cfg.holdoff; // RULE17
        else if (procTick && s_r.hold != 16'h0000)
            s_nxt.hold = s_r.hold - 16'h0001; // RULE17

        // slot, start delay, integration and period counters
        slotStart = 1'b0;
        if (s_r.cfg.syncEn && synSync && !s_r.syncPrev)
        begin
            s_nxt.slotCnt = 16'h0000; // RULE19
            slotStart = 1'b1;
        end
        else if (procTick && s_r.cfg.slotLen != 16'h0000)
        begin
            if (s_r.slotCnt >= s_r.cfg.slotLen - 16'h0001)
            begin
                s_nxt.slotCnt = 16'h0000; // RULE19
                slotStart = 1'b1;
            end
            else
                s_nxt.slotCnt = s_r.slotCnt + 16'h0001;
        end

        intLast = 16'((17'h00001 << s_r.cfg.intShift) - 17'h00001);
        avg = (s_r.acc + {16'h0000, mag}) >> s_r.cfg.intShift;
        decide = 1'b0;
        case (s_r.phase)
            ARC_DELAY:
                if (procTick)
                begin
                    if (s_r.dlyCnt == 16'h0000)
                    begin
                        s_nxt.phase = ARC_INTEG; // RULE19
                        s_nxt.acc = '0;
                        s_nxt.intCnt = '0;
                    end
                    else
                        s_nxt.dlyCnt = s_r.dlyCnt - 16'h0001;
                end
            ARC_INTEG:
                if (rcValid)
                begin
                    s_nxt.acc = s_r.acc + {16'h0000, mag};
                    s_nxt.intCnt = s_r.intCnt + 16'h0001;
                    if (s_r.intCnt == intLast)
                    begin
                        decide = 1'b1; // RULE19
                        s_nxt.acc = '0;
                        s_nxt.intCnt = '0;
                        s_nxt.perLeft = s_r.perLeft - 8'h01;
                        if (s_r.perLeft <= 8'h01)
                            s_nxt.phase = ARC_IDLE;
                    end
                end
            default:
                s_nxt.phase = ARC_IDLE;
        endcase
        if (slotStart)
        begin
            s_nxt.phase = (s_r.cfg.intPer == 8'h00) ? ARC_IDLE : ARC_DELAY;
            s_nxt.dlyCnt = s_r.cfg.startDly; // RULE19
            s_nxt.perLeft = s_r.cfg.intPer;
        end

        // attenuator register update
        delta = immHit ? $signed({3'h0, s_r.cfg.stepImm}) : 11'sd0; // RULE16
        if (decide)
        begin
            if (avg > {16'h0000, s_r.cfg.thrUp})
                delta = delta + $signed({3'h0, s_r.cfg.stepUp}); // RULE14
            else if (avg < {16'h0000, s_r.cfg.thrLo})
                delta = delta - $signed({3'h0, s_r.cfg.stepDn}); // RULE14
            else
                delta = delta - $signed({3'h0, s_r.cfg.bias}); // RULE18
        end
        attSum = $signed({3'h0, s_r.att}) + delta;
        s_nxt.att = arc_sat(attSum); // RULE23
        s_nxt.eout = s_r.cfg.lut[s_r.att[7:5]]; // RULE15 RULE21
        if (procTick)
            s_nxt.expLine = {s_r.expLine[6:0], s_r.att[7:5]}; // RULE22

        // bus slave; writes wait for a tick
        accept = hsel & htrans[1] & hready & (hsize == 3'h2);
        if (s_r.aphWrite)
        begin
            s_nxt.pend = hwdata;
            s_nxt.pendAddr = s_r.aphAddr;
            s_nxt.pendValid = 1'b1;
            s_nxt.aphWrite = 1'b0;
        end
        if (accept)
        begin
            s_nxt.aphWrite = hwrite;
            s_nxt.aphAddr = {haddr[7:2], 2'h0};
            if (!hwrite)
                s_nxt.hrdata = '0;
            if (!hwrite && haddr[31:8] == 24'h000000)
            begin
                case ({haddr[7:2], 2'h0})
                    `ARC_OFS_CTRL: s_nxt.hrdata = {15'h0000,
                        s_r.cfg.expDelay, s_r.cfg.syncEn, s_r.cfg.routeExp,
                        s_r.cfg.capSel, s_r.cfg.muxDelay, s_r.cfg.mode,
                        s_r.cfg.reverse, s_r.cfg.extExpIgnore, s_r.cfg.fmt,
                        s_r.cfg.offsetBin};
                    `ARC_OFS_THR_UP: s_nxt.hrdata[15:0] = s_r.cfg.thrUp;
                    `ARC_OFS_THR_LO: s_nxt.hrdata[15:0] = s_r.cfg.thrLo;
                    `ARC_OFS_THR_IMM: s_nxt.hrdata[15:0] = s_r.cfg.thrImm;
                    `ARC_OFS_STEPS: s_nxt.hrdata = {s_r.cfg.bias,
                        s_r.cfg.stepImm, s_r.cfg.stepDn, s_r.cfg.stepUp};
                    `ARC_OFS_HOLDOFF: s_nxt.hrdata[15:0] = s_r.cfg.holdoff;
                    `ARC_OFS_SLOT: s_nxt.hrdata[15:0] = s_r.cfg.slotLen;
                    `ARC_OFS_TIMING: s_nxt.hrdata = {4'h0, s_r.cfg.intPer,
                        s_r.cfg.intShift, s_r.cfg.startDly};
                    `ARC_OFS_LUT_LO: s_nxt.hrdata = s_r.cfg.lut[3:0];
                    `ARC_OFS_LUT_HI: s_nxt.hrdata = s_r.cfg.lut[7:4];
                    `ARC_OFS_STATUS: s_nxt.hrdata = {15'h0000,
                        (s_r.hold != 16'h0000), s_r.eout, s_r.att};
                    default: s_nxt.hrdata = '0;
                endcase
            end
            if (haddr[31:8] != 24'h000000)
                s_nxt.aphWrite = 1'b0;
        end
        if (s_r.pendValid && procTick)
        begin
            s_nxt.pendValid = 1'b0; // RULE13
            case (s_r.pendAddr)
                `ARC_OFS_CTRL:
                begin
                    s_nxt.cfg.offsetBin = s_r.pend[`ARC_CTRL_OFFSET_BIN];
                    s_nxt.cfg.fmt = s_r.pend[`ARC_CTRL_FMT];
                    s_nxt.cfg.extExpIgnore = s_r.pend[`ARC_CTRL_EXT_EXP_IGNORE];
                    s_nxt.cfg.reverse = s_r.pend[`ARC_CTRL_REVERSE];
                    s_nxt.cfg.mode = arc_mode_t'(s_r.pend[`ARC_CTRL_MODE]);
                    s_nxt.cfg.muxDelay = s_r.pend[`ARC_CTRL_MUX_DELAY];
                    s_nxt.cfg.capSel = s_r.pend[`ARC_CTRL_CAP_SEL];
                    s_nxt.cfg.routeExp = s_r.pend[`ARC_CTRL_ROUTE_EXP];
                    s_nxt.cfg.syncEn = s_r.pend[`ARC_CTRL_SYNC_EN];
                    s_nxt.cfg.expDelay = s_r.pend[`ARC_CTRL_EXP_DELAY];
                end
                `ARC_OFS_THR_UP: s_nxt.cfg.thrUp = s_r.pend[15:0];
                `ARC_OFS_THR_LO: s_nxt.cfg.thrLo = s_r.pend[15:0];
                `ARC_OFS_THR_IMM: s_nxt.cfg.thrImm = s_r.pend[15:0];
                `ARC_OFS_STEPS:
                    {s_nxt.cfg.bias, s_nxt.cfg.stepImm, s_nxt.cfg.stepDn,
                        s_nxt.cfg.stepUp} = s_r.pend;
                `ARC_OFS_HOLDOFF: s_nxt.cfg.holdoff = s_r.pend[15:0];
                `ARC_OFS_SLOT: s_nxt.cfg.slotLen = s_r.pend[15:0];
                `ARC_OFS_TIMING:
                begin
                    s_nxt.cfg.startDly = s_r.pend[`ARC_TIM_START_DLY];
                    s_nxt.cfg.intShift = s_r.pend[`ARC_TIM_INT_SHIFT];
                    s_nxt.cfg.intPer = s_r.pend[`ARC_TIM_INT_PER];
                end
                `ARC_OFS_LUT_LO: s_nxt.cfg.lut[3:0] = s_r.pend;
                `ARC_OFS_LUT_HI: s_nxt.cfg.lut[7:4] = s_r.pend;
                default: s_nxt.cfg = s_r.cfg;
            endcase
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            s_r <= `ARC_STATE_RST;
        else
            s_r <= s_nxt;
    end

    assign hreadyout = ~s_r.pendValid;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign smp_out = s_r.out;
    assign gain_code = s_r.eout;

endmodule

`default_nettype wire

// ===== arc_map.svh
// register map and timing constants
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH

// register byte offsets
`define ARC_OFS_CTRL 8'h00
`define ARC_OFS_THR_UP 8'h04
`define ARC_OFS_THR_LO 8'h08
`define ARC_OFS_THR_IMM 8'h0C
`define ARC_OFS_STEPS 8'h10
`define ARC_OFS_HOLDOFF 8'h14
`define ARC_OFS_SLOT 8'h18
`define ARC_OFS_TIMING 8'h1C
`define ARC_OFS_LUT_LO 8'h20
`define ARC_OFS_LUT_HI 8'h24
`define ARC_OFS_STATUS 8'h28

// control register fields
`define ARC_CTRL_OFFSET_BIN 0
`define ARC_CTRL_FMT 2:1
`define ARC_CTRL_EXT_EXP_IGNORE 3
`define ARC_CTRL_REVERSE 4
`define ARC_CTRL_MODE 6:5
`define ARC_CTRL_MUX_DELAY 9:7
`define ARC_CTRL_CAP_SEL 11:10
`define ARC_CTRL_ROUTE_EXP 12
`define ARC_CTRL_SYNC_EN 13
`define ARC_CTRL_EXP_DELAY 16:14

// timing register fields
`define ARC_TIM_START_DLY 15:0
`define ARC_TIM_INT_SHIFT 19:16
`define ARC_TIM_INT_PER 27:20

// reset values
`define ARC_CFG_RST '0
`define ARC_STATE_RST '0

// clk_sys cycles per processing tick
`define ARC_PROC_DIV 8

`endif

// ===== arc_monitor.sv
// port checks bound into the design
`timescale 1ns/1ps
`default_nettype none

module arc_monitor
    import arc_pkg::*;
#(
    parameter int DIV = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire arc_pkg::arc_smp_t smp_out,
    input wire logic [7:0] gain_code
);
    logic taken;
    logic rdTaken;
    logic wrData_r;
    assign taken = hsel && htrans[1] && hready && hsize == 3'b010;
    assign rdTaken = taken && !hwrite;
    // write data phase
    always_ff @(posedge clk_sys)
    begin
        wrData_r <= nrst && taken && hwrite;
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ----
    // properties
    // ----
    AST_RESET_OUTS: assert property (disable iff (1'b0) !nrst |=>
        smp_out == '0 && gain_code == 8'h00 && hreadyout)
        else $error("reset outputs");
    AST_HRESP_OKAY: assert property (hresp == 1'b0)
        else $error("hresp");
    AST_VALID_PULSE: assert property (
        smp_out.valid |=> !smp_out.valid [*7])
        else $error("valid width");
    AST_WR_STALL: assert property (wrData_r |=> !hreadyout)
        else $error("write stall");
    AST_WR_CAUSE: assert property (
        $fell(hreadyout) |-> $past(wrData_r))
        else $error("stall cause");
    AST_WR_BOUND: assert property (
        $fell(hreadyout) |-> ##[1:8] hreadyout)
        else $error("commit late");
    AST_RD_HOLD: assert property ($changed(hrdata) |-> $past(rdTaken))
        else $error("hrdata hold");
    AST_DATA_HOLD: assert property (
        $changed(smp_out.data) |-> smp_out.valid)
        else $error("data hold");
    AST_GAIN_SPACING: assert property (
        $changed(gain_code) |=> $stable(gain_code) [*7])
        else $error("gain spacing");
endmodule

bind arc_input_range arc_monitor #(.DIV(DIV)) mon (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .smp_out(smp_out),
    .gain_code(gain_code)
);
`default_nettype wire

// ===== arc_pkg.sv
// shared types of the range control block
package arc_pkg;

    typedef enum logic [1:0] {ARC_CONT, ARC_GATED, ARC_INTERP, ARC_MUX} arc_mode_t;

    typedef enum logic [1:0] {ARC_IDLE, ARC_DELAY, ARC_INTEG} arc_phase_t;

    typedef struct packed {
        logic offsetBin;
        logic [1:0] fmt;
        logic extExpIgnore;
        logic reverse;
        arc_mode_t mode;
        logic [2:0] muxDelay;
        logic [1:0] capSel;
        logic routeExp;
        logic syncEn;
        logic [2:0] expDelay;
        logic [15:0] thrUp;
        logic [15:0] thrLo;
        logic [15:0] thrImm;
        logic [7:0] stepUp;
        logic [7:0] stepDn;
        logic [7:0] stepImm;
        logic [7:0] bias;
        logic [15:0] holdoff;
        logic [15:0] slotLen;
        logic [15:0] startDly;
        logic [3:0] intShift;
        logic [7:0] intPer;
        logic [7:0][7:0] lut;
    } arc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic [3:0] exp;
    } arc_smp_t;

endpackage

// ===== arc_sync2.sv
// two flip-flop synchroniser
`timescale 1ns/1ps
`default_nettype none

module arc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } arc_sync_st_t;

    arc_sync_st_t s_r;
    arc_sync_st_t s_nxt;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("arc_sync2: WIDTH must be at least 1");
    end

    always_comb
    begin
        s_nxt.meta = asyncIn;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign syncOut = s_r.sync;

endmodule

`default_nettype wire

// ===== tb.sv
// self-checking bench
`timescale 1ns/1ps
`default_nettype none
`include "arc_map.svh"

module tb;
    import arc_pkg::*;
    typedef struct {
        logic [31:0] ctrl;
        logic [1:0] enMode;
        logic [16:0] bus;
        logic [15:0] data;
        logic [3:0] exp;
    } arc_row_t;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic adcClk;
    logic [16:0] adcData;
    logic enableN;
    logic [1:0] enMode = 2'h0;
    logic [16:0] base = 17'h0;
    arc_smp_t smpOut;
    logic [7:0] gainCode;
    logic [31:0] rd;
    arc_row_t rows[$];
    int mismatches = 0;
    int samplesChecked = 0;
    int cycles = 0;

    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    arc_input_range #(.DIV(8)) dut (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .adc_clk(adcClk),
        .adc_data(adcData),
        .input_enable_n(enableN),
        .sync_pulse_in(1'b0),
        .smp_out(smpOut),
        .gain_code(gainCode)
    );

    arc_adc_model adc (
        .enMode(enMode),
        .base(base),
        .adcClk(adcClk),
        .adcData(adcData),
        .enableN(enableN)
    );

    // ----
    // tasks
    // ----
    task automatic chk(input string name, input logic [31:0] e,
        input logic [31:0] got);
        samplesChecked++;
        if (got !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", mismatches, samplesChecked);
        if (mismatches == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // single word transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic waitValid(input int n);
        repeat (n)
        begin
            do @(posedge clk_sys); while (smpOut.valid !== 1'b1);
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        int n;
        rows = '{
            '{32'h000, 2'h0, 17'h01234, 16'h1234, 4'h0},
            '{32'h001, 2'h0, 17'h01234, 16'h9234, 4'h0},
            '{32'h002, 2'h0, 17'h1ABCD, 16'hD5E4, 4'h5},
            '{32'h00A, 2'h0, 17'h1ABCD, 16'hD5E4, 4'h0},
            '{32'h004, 2'h0, 17'h1ABCD, 16'hD5E6, 4'h1},
            '{32'h007, 2'h0, 17'h1ABCD, 16'h55E6, 4'h1},
            '{32'h010, 2'h0, 17'h00006, 16'hC000, 4'h0},
            '{32'h420, 2'h0, 17'h01234, 16'h1234, 4'h0},
            '{32'h840, 2'h1, 17'h01234, 16'h0000, 4'h0},
            '{32'hC00, 2'h0, 17'h01234, 16'h1234, 4'h0}};
        for (int i = 0; i < 8; i++)
            rows.push_back('{32'h60 | (i << 7), 2'h2, 17'h01230,
                16'h1230 | i[15:0], 4'h0});
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, `ARC_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        ahb(1'b0, 8'h2C, 32'h0);
        chk("unmapped read", 32'h0, rd);
        foreach (rows[i])
        begin
            enMode <= rows[i].enMode;
            base <= rows[i].bus;
            ahb(1'b1, `ARC_OFS_CTRL, rows[i].ctrl);
            waitValid(4);
            chk("sample data", 32'(rows[i].data), 32'(smpOut.data));
            chk("sample exponent", 32'(rows[i].exp), 32'(smpOut.exp));
        end
        enMode <= 2'h1;
        ahb(1'b1, `ARC_OFS_CTRL, 32'h20);
        repeat (8) @(posedge clk_sys);
        n = 0;
        repeat (80)
        begin
            @(posedge clk_sys);
            n += (smpOut.valid === 1'b1) ? 1 : 0;
        end
        chk("gated stall", 32'h0, 32'(n));
        enMode <= 2'h0;
        base <= 17'h01234;
        ahb(1'b1, `ARC_OFS_CTRL, 32'h0);
        ahb(1'b1, `ARC_OFS_THR_IMM, 32'hFFFF);
        ahb(1'b1, `ARC_OFS_LUT_LO, 32'h44332211);
        ahb(1'b1, `ARC_OFS_LUT_HI, 32'h88776655);
        ahb(1'b1, `ARC_OFS_HOLDOFF, 32'h28);
        ahb(1'b1, `ARC_OFS_STEPS, 32'h00200000);
        ahb(1'b1, `ARC_OFS_THR_IMM, 32'h1000);
        repeat (100) @(posedge clk_sys);
        ahb(1'b0, `ARC_OFS_STATUS, 32'h0);
        chk("att one hit", 32'h20, 32'(rd[7:0]));
        chk("gain one", 32'h22, 32'(gainCode));
        repeat (3000) @(posedge clk_sys);
        ahb(1'b0, `ARC_OFS_STATUS, 32'h0);
        chk("att at ceiling", 32'hFF, 32'(rd[7:0]));
        chk("gain seven", 32'h88, 32'(gainCode));
        ahb(1'b1, `ARC_OFS_CTRL, 32'h1000);
        waitValid(4);
        chk("route exp", 32'h7, 32'(smpOut.exp));
        ahb(1'b1, `ARC_OFS_THR_IMM, 32'hFFFF);
        ahb(1'b1, `ARC_OFS_THR_UP, 32'hFFFF);
        ahb(1'b1, `ARC_OFS_TIMING, 32'h00120000);
        ahb(1'b1, `ARC_OFS_SLOT, 32'h10);
        ahb(1'b1, `ARC_OFS_STEPS, 32'h10000000);
        repeat (3000) @(posedge clk_sys);
        ahb(1'b0, `ARC_OFS_STATUS, 32'h0);
        chk("att at floor", 32'h0, 32'(rd[7:0]));
        ahb(1'b1, `ARC_OFS_STEPS, 32'h00000008);
        ahb(1'b1, `ARC_OFS_THR_UP, 32'h1000);
        repeat (600) @(posedge clk_sys);
        ahb(1'b0, `ARC_OFS_STATUS, 32'h0);
        chk("att stepped up", 32'h1, 32'(rd[7:0] != 0 && rd[2:0] == 0));
        tally_and_finish();
    end
endmodule
`default_nettype wire
